// *** rtl/tiof_timer_io.sv ***
// Timer input roles, prescaler, output actions and event flags behind APB
`timescale 1ns/100ps
`include "tiof_cfg.svh"
module tiof_timer_io #(
   parameter int ABW = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pclken,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ABW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic input_pin_first,
   input wire logic input_pin_second,
   input wire logic prescale_in,
   input wire logic bicapture_mode,
   input wire tiof_pkg::tiof_core_evt_s core_evt,
   input wire tiof_pkg::tiof_irq_mask_s irq_mask,
   output logic [1:0] pin_level,
   output logic [1:0] pin_event,
   output tiof_pkg::tiof_roles_s pin_roles,
   output logic prescale_tick,
   output logic output_pin_first,
   output logic output_pin_second,
   output logic on_chip_event,
   output logic sw_capture0_req,
   output logic sw_capture1_req,
   output tiof_pkg::tiof_irq_s irq
);
   import tiof_pkg::*;

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] in_cfg;
      logic [7:0] preset;
      logic [7:0] out_a_cfg;
      logic [7:0] out_b_cfg;
      logic [7:0] presc_cnt;
      logic [7:0] flags;
      logic presc_tick;
      logic out_a;
      logic out_b;
      logic on_chip;
      logic sw_cap0;
      logic sw_cap1;
      tiof_roles_s roles;
      tiof_irq_s irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } tiof_state_s;

   tiof_state_s st_reg;
   tiof_state_s st_next;
   logic [ABW-3:0] word;
   logic hit;
   logic wr;
   logic flag_wr;
   logic [1:0] pins;
   logic [1:0] sels [2];

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic tiof_roles_s decode_roles(input logic [3:0] code);
      tiof_roles_s r;
      r = '{TIOF_ROLE_NONE, TIOF_ROLE_NONE};
      case (code)
         4'h1: r = '{TIOF_ROLE_NONE, TIOF_ROLE_TRIGGER};
         4'h2: r = '{TIOF_ROLE_GATE, TIOF_ROLE_NONE};
         4'h3: r = '{TIOF_ROLE_GATE, TIOF_ROLE_TRIGGER};
         4'h4: r = '{TIOF_ROLE_NONE, TIOF_ROLE_EXT_CLOCK};
         4'h5: r = '{TIOF_ROLE_TRIGGER, TIOF_ROLE_NONE};
         4'h6: r = '{TIOF_ROLE_GATE, TIOF_ROLE_EXT_CLOCK};
         4'h7: r = '{TIOF_ROLE_TRIGGER, TIOF_ROLE_TRIGGER};
         4'h8: r = '{TIOF_ROLE_CLOCK_UP, TIOF_ROLE_CLOCK_DOWN};
         4'h9: r = '{TIOF_ROLE_UP_DOWN, TIOF_ROLE_EXT_CLOCK};
         4'hA: r = '{TIOF_ROLE_TRIG_UP, TIOF_ROLE_TRIG_DOWN};
         4'hB: r = '{TIOF_ROLE_UP_DOWN, TIOF_ROLE_NONE};
         4'hC: r = '{TIOF_ROLE_AUTODISCR, TIOF_ROLE_AUTODISCR};
         4'hD: r = '{TIOF_ROLE_TRIGGER, TIOF_ROLE_EXT_CLOCK};
         4'hE: r = '{TIOF_ROLE_EXT_CLOCK, TIOF_ROLE_TRIGGER};
         4'hF: r = '{TIOF_ROLE_TRIGGER, TIOF_ROLE_GATE};
         default: r = '{TIOF_ROLE_NONE, TIOF_ROLE_NONE};
      endcase
      return r;
   endfunction : decode_roles

   // Shared by both output pins; unused events leave the mask at 11
   function automatic logic pin_next(input logic cur, input logic [7:0] cfg,
                                     input tiof_core_evt_s e);
      logic [1:0] act;
      act = `TIOF_ACT_NONE;
      if (e.match0)
         act = act & cfg[`TIOF_M0_HI:`TIOF_M0_LO];
      if (e.match1)
         act = act & cfg[`TIOF_M1_HI:`TIOF_M1_LO];
      if (e.wrap)
         act = act & cfg[`TIOF_WR_HI:`TIOF_WR_LO];
      case (act)
         `TIOF_ACT_SET: return 1'b1;
         `TIOF_ACT_TOGGLE: return ~cur;
         `TIOF_ACT_CLEAR: return 1'b0;
         default: return cur;
      endcase
   endfunction : pin_next

   // ----------------------------------------------------------------------
   // Input pins
   // ----------------------------------------------------------------------
   assign pins = {input_pin_second, input_pin_first};
   assign sels[0] = st_reg.in_cfg[`TIOF_EDGE_A_HI:`TIOF_EDGE_A_LO];
   assign sels[1] = st_reg.in_cfg[`TIOF_EDGE_B_HI:`TIOF_EDGE_B_LO];

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_pin
         tiof_edge u_edge (
            .pclk(pclk),
            .presetn(presetn),
            .pclken(pclken),
            .pin(pins[gi]),
            .edge_sel(sels[gi]),
            .level(pin_level[gi]),
            .evt(pin_event[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   assign word = paddr[ABW-1:2];
   assign hit = (paddr[1:0] == 2'b00) &&
      (word == (ABW-2)'(`TIOF_IDX_IN_CFG) || word == (ABW-2)'(`TIOF_IDX_PRESET) ||
       word == (ABW-2)'(`TIOF_IDX_OUT_A) || word == (ABW-2)'(`TIOF_IDX_OUT_B) ||
       word == (ABW-2)'(`TIOF_IDX_FLAGS));
   // Writes land only at the completing edge, low byte lane only
   assign wr = psel & penable & st_reg.pready & pwrite & pstrb[0] & hit;
   assign flag_wr = wr && word == (ABW-2)'(`TIOF_IDX_FLAGS);

   always_comb
   begin
      logic base_a;
      logic base_b;
      logic [7:0] f;
      logic [7:0] w;
      base_a = st_reg.out_a;
      base_b = st_reg.out_b;
      f = st_reg.flags;
      w = pwdata[7:0];
      st_next = st_reg;

      if (wr && word == (ABW-2)'(`TIOF_IDX_IN_CFG))
         st_next.in_cfg = w;
      if (wr && word == (ABW-2)'(`TIOF_IDX_PRESET))
         st_next.preset = w;
      if (wr && word == (ABW-2)'(`TIOF_IDX_OUT_A))
      begin
         st_next.out_a_cfg = w;
         base_a = w[`TIOF_LEVEL_BIT];
      end
      if (wr && word == (ABW-2)'(`TIOF_IDX_OUT_B))
      begin
         st_next.out_b_cfg = w;
         base_b = w[`TIOF_LEVEL_BIT];
      end

      st_next.roles = decode_roles(st_reg.in_cfg[`TIOF_ROLE_HI:`TIOF_ROLE_LO]);

      // Reload beats underflow so a counter reload restarts a full period
      st_next.presc_tick = 1'b0;
      if (core_evt.reload)
         st_next.presc_cnt = st_reg.preset;
      else if (prescale_in)
      begin
         if (st_reg.presc_cnt == `TIOF_RST_CNT)
         begin
            st_next.presc_cnt = st_reg.preset;
            st_next.presc_tick = 1'b1;
         end
         else
            st_next.presc_cnt = st_reg.presc_cnt - 8'h01;
      end

      // Hardware action applies on top of a preset written in the same cycle
      st_next.out_a = pin_next(base_a, st_reg.out_a_cfg, core_evt);
      st_next.out_b = pin_next(base_b, st_reg.out_b_cfg, core_evt);

      st_next.on_chip = (core_evt.match0 & st_reg.out_a_cfg[`TIOF_PULSE_BIT])
         | (core_evt.wrap & st_reg.out_b_cfg[`TIOF_PULSE_BIT]);

      st_next.sw_cap0 = flag_wr & w[`TIOF_F_CP0];
      st_next.sw_cap1 = flag_wr & w[`TIOF_F_CP1] & ~bicapture_mode;

      if (flag_wr)
      begin
         f[`TIOF_F_CP0] = w[`TIOF_F_CP0];
         f[`TIOF_F_CP1] = (st_reg.flags[`TIOF_F_CP1] & w[`TIOF_F_CP1]) |
            st_next.sw_cap1;
         f[`TIOF_F_CM0:`TIOF_F_WRAP] = st_reg.flags[`TIOF_F_CM0:`TIOF_F_WRAP] &
            w[`TIOF_F_CM0:`TIOF_F_WRAP];
         f[`TIOF_F_OCP0:`TIOF_F_OCM0] = st_reg.flags[`TIOF_F_OCP0:`TIOF_F_OCM0] &
            w[`TIOF_F_OCP0:`TIOF_F_OCM0];
         f[`TIOF_F_COMB] = w[`TIOF_F_COMB];
      end
      // Hardware sets win over a clear in the same cycle
      f[`TIOF_F_OCP0] = f[`TIOF_F_OCP0] | st_next.sw_cap0 |
         (core_evt.capture0 & st_reg.flags[`TIOF_F_CP0]);
      f[`TIOF_F_OCM0] = f[`TIOF_F_OCM0] | (core_evt.match0 & st_reg.flags[`TIOF_F_CM0]);
      f[`TIOF_F_CP0] = f[`TIOF_F_CP0] | core_evt.capture0;
      f[`TIOF_F_CP1] = f[`TIOF_F_CP1] | core_evt.capture1;
      f[`TIOF_F_CM0] = f[`TIOF_F_CM0] | core_evt.match0;
      f[`TIOF_F_CM1] = f[`TIOF_F_CM1] | core_evt.match1;
      f[`TIOF_F_WRAP] = f[`TIOF_F_WRAP] | core_evt.wrap;
      st_next.flags = f;

      // Requests follow the stored flags one cycle later
      st_next.irq.capture = irq_mask.global_timer_irq_enable &
         (st_reg.flags[`TIOF_F_COMB] ?
            (st_reg.flags[`TIOF_F_CP0] & irq_mask.capture0_irq_mask &
             st_reg.flags[`TIOF_F_CP1] & irq_mask.capture1_irq_mask) :
            ((st_reg.flags[`TIOF_F_CP0] & irq_mask.capture0_irq_mask) |
             (st_reg.flags[`TIOF_F_CP1] & irq_mask.capture1_irq_mask)));
      st_next.irq.match0 = irq_mask.global_timer_irq_enable &
         irq_mask.match0_irq_mask & st_reg.flags[`TIOF_F_CM0];
      st_next.irq.match1 = irq_mask.global_timer_irq_enable &
         irq_mask.match1_irq_mask & st_reg.flags[`TIOF_F_CM1];
      st_next.irq.wrap = irq_mask.global_timer_irq_enable &
         irq_mask.wrap_irq_mask & st_reg.flags[`TIOF_F_WRAP];

      // One wait state: answer rises the cycle after the access phase opens
      st_next.pready = psel & penable & ~st_reg.pready;
      st_next.pslverr = 1'b0;
      st_next.prdata = '0;
      if (st_next.pready)
      begin
         st_next.pslverr = ~hit;
         if (!pwrite && hit)
         begin
            if (word == (ABW-2)'(`TIOF_IDX_IN_CFG))
               st_next.prdata[7:0] = st_reg.in_cfg;
            else if (word == (ABW-2)'(`TIOF_IDX_PRESET))
               st_next.prdata[7:0] = st_reg.preset;
            else if (word == (ABW-2)'(`TIOF_IDX_OUT_A))
               st_next.prdata[7:0] = {st_reg.out_a_cfg[7:1], st_reg.out_a};
            else if (word == (ABW-2)'(`TIOF_IDX_OUT_B))
               st_next.prdata[7:0] = {st_reg.out_b_cfg[7:1], st_reg.out_b};
            else
               st_next.prdata[7:0] = st_reg.flags;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_reg <= '0;
         st_reg.in_cfg <= `TIOF_RST_REG;
         st_reg.preset <= `TIOF_RST_REG;
         st_reg.out_a_cfg <= `TIOF_RST_REG;
         st_reg.out_b_cfg <= `TIOF_RST_REG;
         st_reg.flags <= `TIOF_RST_REG;
         st_reg.presc_cnt <= `TIOF_RST_CNT;
      end
      else if (pclken)
         st_reg <= st_next;
   end

   assign prdata = st_reg.prdata;
   assign pready = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign pin_roles = st_reg.roles;
   assign prescale_tick = st_reg.presc_tick;
   assign output_pin_first = st_reg.out_a;
   assign output_pin_second = st_reg.out_b;
   assign on_chip_event = st_reg.on_chip;
   assign sw_capture0_req = st_reg.sw_cap0;
   assign sw_capture1_req = st_reg.sw_cap1;
   assign irq = st_reg.irq;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_flag_write_one(int b);
      pclken && flag_wr && pwdata[b];
   endsequence

   property p_roles_auto;
      pclken && st_reg.in_cfg[7:4] == 4'hC |=>
         pin_roles.role_a == TIOF_ROLE_AUTODISCR && pin_roles.role_b == TIOF_ROLE_AUTODISCR;
   endproperty
   a_roles_auto: assert property (p_roles_auto)
      else $error("role code 1100 not decoded as autodiscrimination");

   property p_presc_wrap;
      pclken && prescale_in && !core_evt.reload && st_reg.presc_cnt == `TIOF_RST_CNT |=>
         prescale_tick && st_reg.presc_cnt == $past(st_reg.preset);
   endproperty
   a_presc_wrap: assert property (p_presc_wrap)
      else $error("prescaler underflow did not tick and reload");

   property p_presc_reload;
      pclken && core_evt.reload |=> !prescale_tick && st_reg.presc_cnt == $past(st_reg.preset);
   endproperty
   a_presc_reload: assert property (p_presc_reload)
      else $error("counter reload did not load the preset");

   // Bitwise AND of 01 and 10 is 00, the drive-high action
   property p_out_and;
      pclken && !wr && core_evt.match0 && core_evt.wrap && !core_evt.match1 &&
         st_reg.out_a_cfg[`TIOF_M0_HI:`TIOF_M0_LO] == `TIOF_ACT_TOGGLE &&
         st_reg.out_a_cfg[`TIOF_WR_HI:`TIOF_WR_LO] == `TIOF_ACT_CLEAR |=>
         output_pin_first == 1'b1;
   endproperty
   a_out_and: assert property (p_out_and)
      else $error("toggle AND clear should drive pin A high");

   property p_pulse;
      pclken |=> on_chip_event == $past((core_evt.match0 && st_reg.out_a_cfg[`TIOF_PULSE_BIT]) ||
         (core_evt.wrap && st_reg.out_b_cfg[`TIOF_PULSE_BIT]));
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("on-chip event pulse mismatch");

   property p_match0_flag_irq;
      pclken && core_evt.match0 ##1 pclken && irq_mask.global_timer_irq_enable &&
         irq_mask.match0_irq_mask |=> irq.match0;
   endproperty
   a_match0_flag_irq: assert property (p_match0_flag_irq)
      else $error("compare-0 flag lost or interrupt missing");

   property p_capture_and;
      pclken && st_reg.flags[`TIOF_F_COMB] && st_reg.flags[`TIOF_F_CP0] &&
         !st_reg.flags[`TIOF_F_CP1] |=> !irq.capture;
   endproperty
   a_capture_and: assert property (p_capture_and)
      else $error("AND combine raised capture interrupt with one capture");

   property p_sw_cap0;
      s_flag_write_one(`TIOF_F_CP0) |=> sw_capture0_req && st_reg.flags[`TIOF_F_CP0] &&
         st_reg.flags[`TIOF_F_OCP0];
   endproperty
   a_sw_cap0: assert property (p_sw_cap0)
      else $error("software capture-0 write had no effect");

   property p_sw_cap1_bicap;
      s_flag_write_one(`TIOF_F_CP1) ##0 bicapture_mode |=> !sw_capture1_req;
   endproperty
   a_sw_cap1_bicap: assert property (p_sw_cap1_bicap)
      else $error("software capture-1 acted in bicapture mode");

   property p_wrap_keep;
      pclken && flag_wr && pwdata[`TIOF_F_WRAP] && st_reg.flags[`TIOF_F_WRAP] |=>
         st_reg.flags[`TIOF_F_WRAP];
   endproperty
   a_wrap_keep: assert property (p_wrap_keep)
      else $error("write of one cleared the wrap flag");

   property p_apb_answer;
      pclken && psel && penable && !pready |=> pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer)
      else $error("APB access not answered after one wait state");
endmodule : tiof_timer_io

// *** include/tiof_cfg.svh ***
// Register indices, field positions, codes and reset values of the timer I/O block
`ifndef TIOF_CFG_SVH
`define TIOF_CFG_SVH
// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define TIOF_IDX_IN_CFG 8'hFA
`define TIOF_IDX_PRESET 8'hFB
`define TIOF_IDX_OUT_A 8'hFC
`define TIOF_IDX_OUT_B 8'hFD
`define TIOF_IDX_FLAGS 8'hFE
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TIOF_RST_REG 8'h00
`define TIOF_RST_CNT 8'h00
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TIOF_ROLE_HI 7
`define TIOF_ROLE_LO 4
`define TIOF_EDGE_A_HI 3
`define TIOF_EDGE_A_LO 2
`define TIOF_EDGE_B_HI 1
`define TIOF_EDGE_B_LO 0
`define TIOF_M0_HI 7
`define TIOF_M0_LO 6
`define TIOF_M1_HI 5
`define TIOF_M1_LO 4
`define TIOF_WR_HI 3
`define TIOF_WR_LO 2
`define TIOF_PULSE_BIT 1
`define TIOF_LEVEL_BIT 0
`define TIOF_F_CP0 7
`define TIOF_F_CP1 6
`define TIOF_F_CM0 5
`define TIOF_F_CM1 4
`define TIOF_F_WRAP 3
`define TIOF_F_OCP0 2
`define TIOF_F_OCM0 1
`define TIOF_F_COMB 0
// ----------------------------------------------------------------------
// Codes
// ----------------------------------------------------------------------
`define TIOF_ACT_SET 2'b00
`define TIOF_ACT_TOGGLE 2'b01
`define TIOF_ACT_CLEAR 2'b10
`define TIOF_ACT_NONE 2'b11
`define TIOF_EDGE_FALL_BIT 0
`define TIOF_EDGE_RISE_BIT 1
`endif

// *** include/tiof_pkg.sv ***
// Types shared by the timer I/O block
package tiof_pkg;
   typedef enum logic [3:0] {
      TIOF_ROLE_NONE = 4'h0,
      TIOF_ROLE_GATE = 4'h1,
      TIOF_ROLE_TRIGGER = 4'h2,
      TIOF_ROLE_EXT_CLOCK = 4'h3,
      TIOF_ROLE_CLOCK_UP = 4'h4,
      TIOF_ROLE_CLOCK_DOWN = 4'h5,
      TIOF_ROLE_UP_DOWN = 4'h6,
      TIOF_ROLE_TRIG_UP = 4'h7,
      TIOF_ROLE_TRIG_DOWN = 4'h8,
      TIOF_ROLE_AUTODISCR = 4'h9
   } tiof_role_e;
   typedef struct packed {
      tiof_role_e role_a;
      tiof_role_e role_b;
   } tiof_roles_s;
   typedef struct packed {
      logic match0;
      logic match1;
      logic wrap;
      logic capture0;
      logic capture1;
      logic reload;
   } tiof_core_evt_s;
   typedef struct packed {
      logic global_timer_irq_enable;
      logic capture0_irq_mask;
      logic capture1_irq_mask;
      logic match0_irq_mask;
      logic match1_irq_mask;
      logic wrap_irq_mask;
   } tiof_irq_mask_s;
   typedef struct packed {
      logic capture;
      logic match0;
      logic match1;
      logic wrap;
   } tiof_irq_s;
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic last;
      logic evt;
   } tiof_edge_s;
endpackage : tiof_pkg

// *** rtl/tiof_edge.sv ***
// Input pin synchroniser and edge detector
`timescale 1ns/100ps
`include "tiof_cfg.svh"
module tiof_edge (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pclken,
   input wire logic pin,
   input wire logic [1:0] edge_sel,
   output logic level,
   output logic evt
);
   import tiof_pkg::*;
   tiof_edge_s edge_reg;
   tiof_edge_s edge_next;
   logic rise;
   logic fall;

   assign rise = edge_reg.sync2 & ~edge_reg.last;
   assign fall = ~edge_reg.sync2 & edge_reg.last;

   always_comb
   begin
      edge_next = edge_reg;
      edge_next.sync1 = pin;
      edge_next.sync2 = edge_reg.sync1;
      edge_next.last = edge_reg.sync2;
      edge_next.evt = (rise & edge_sel[`TIOF_EDGE_RISE_BIT])
         | (fall & edge_sel[`TIOF_EDGE_FALL_BIT]);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         edge_reg <= '0;
      else if (pclken)
         edge_reg <= edge_next;
   end

   assign level = edge_reg.sync2;
   assign evt = edge_reg.evt;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_edge_rise;
      pclken && rise && edge_sel[`TIOF_EDGE_RISE_BIT] |=> evt;
   endproperty
   a_edge_rise: assert property (p_edge_rise)
      else $error("qualifying rising edge gave no event");

   property p_edge_off;
      pclken && edge_sel == 2'b00 |=> !evt;
   endproperty
   a_edge_off: assert property (p_edge_off)
      else $error("event seen with edge detection disabled");
endmodule : tiof_edge

// *** sim/tiof_pin_model.sv ***
// Far-side model of the two timer input pins
`timescale 1ns/100ps
module tiof_pin_model (
   input wire logic pclk,
   input wire logic [1:0] level_req,
   output logic [1:0] pins
);
   // Push-pull source: pins always hold a defined level
   initial pins = 2'b00;
   // Pins move just after an edge, like a board signal
   always @(posedge pclk)
      pins <= level_req;
endmodule : tiof_pin_model

// *** sim/tiof_timer_io_test.sv ***
// Self-checking bench of the timer I/O block
`timescale 1ns/100ps
`include "tiof_cfg.svh"
module tiof_timer_io_test;
   import tiof_pkg::*;
   localparam logic [7:0] I_CFG = `TIOF_IDX_IN_CFG;
   localparam logic [7:0] I_PRE = `TIOF_IDX_PRESET;
   localparam logic [7:0] I_OA = `TIOF_IDX_OUT_A;
   localparam logic [7:0] I_OB = `TIOF_IDX_OUT_B;
   localparam logic [7:0] I_FL = `TIOF_IDX_FLAGS;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic bicap = 1'b0, pready, pslverr, tick, out_a, out_b, chip, sw0, sw1, err, p, x;
   logic [1:0] drv = 2'b00, pins, pev, lvl;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   tiof_core_evt_s core_evt = '0;
   tiof_irq_mask_s irq_mask = '1;
   tiof_roles_s roles;
   tiof_irq_s irq;
   int errors = 0, check_count = 0, n_pe = 0, n_chip = 0, n_sw0 = 0, n_sw1 = 0, s0, s1;
   tiof_timer_io dut_u (.pclk(pclk), .presetn(presetn), .pclken(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .input_pin_first(pins[0]),
      .input_pin_second(pins[1]), .prescale_in(1'b1), .bicapture_mode(bicap),
      .core_evt(core_evt), .irq_mask(irq_mask), .pin_level(lvl), .pin_event(pev),
      .pin_roles(roles), .prescale_tick(tick), .output_pin_first(out_a),
      .output_pin_second(out_b), .on_chip_event(chip), .sw_capture0_req(sw0),
      .sw_capture1_req(sw1), .irq(irq));
   tiof_pin_model pin_u (.pclk(pclk), .level_req(drv), .pins(pins));
   initial forever #10 pclk = ~pclk;
   always @(posedge pclk)
   begin
      n_pe <= n_pe + pev[0] + pev[1];
      n_chip <= n_chip + chip;
      n_sw0 <= n_sw0 + sw0;
      n_sw1 <= n_sw1 + sw1;
   end
   // ------
   // Tasks
   // ------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   // Leading edge keeps release and next setup in separate steps
   task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d,
                      output logic [7:0] r);
      int t;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, i, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do
      begin
         @(posedge pclk);
         t++;
      end
      while (pready !== 1'b1 && t < 50);
      if (t >= 50)
         errors++;
      r = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      logic [7:0] r;
      apb(1'b1, i, d, r);
   endtask : wr
   task automatic rdc(input logic [7:0] i, input logic [7:0] e);
      logic [7:0] r;
      apb(1'b0, i, 8'h00, r);
      check({24'h0, r}, {24'h0, e});
   endtask : rdc
   task automatic pulse(input logic [5:0] e);
      core_evt <= e;
      @(posedge pclk);
      core_evt <= '0;
      cyc(2);
   endtask : pulse
   task automatic role(input logic [7:0] c, input tiof_role_e a, input tiof_role_e b);
      wr(I_CFG, c);
      cyc(2);
      check(roles, {a, b});
   endtask : role
   // Cycles between two prescaler ticks, bounded
   task automatic gap(input int e);
      int t;
      t = 0;
      while (tick !== 1'b1 && t < 600)
      begin
         cyc(1);
         t++;
      end
      t = 0;
      do
      begin
         cyc(1);
         t++;
      end
      while (tick !== 1'b1 && t < 600);
      check(t, e);
   endtask : gap
   task automatic results;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results
   // ------
   // Scenarios
   // ------
   initial
   begin
      #200000;
      errors++;
      results();
   end
   initial
   begin
      cyc(4);
      presetn <= 1'b1;
      for (int k = 0; k < 5; k++)
         rdc(8'hFA + k[7:0], 8'h00);
      gap(1);
      rdc(8'h10, 8'h00);
      check(err, 1'b1);
      role(8'h30, TIOF_ROLE_GATE, TIOF_ROLE_TRIGGER);
      role(8'h80, TIOF_ROLE_CLOCK_UP, TIOF_ROLE_CLOCK_DOWN);
      role(8'hC0, TIOF_ROLE_AUTODISCR, TIOF_ROLE_AUTODISCR);
      for (int e = 0; e < 4; e++)
      begin
         wr(I_CFG, {4'h0, e[1:0], e[1:0]});
         s0 = n_pe;
         drv <= 2'b11;
         cyc(4);
         check(lvl, 2'b11);
         drv <= 2'b00;
         cyc(6);
         check(n_pe - s0, 2 * (e[0] + e[1]));
      end
      wr(I_PRE, 8'h02);
      cyc(8);
      gap(3);
      rdc(I_PRE, 8'h02);
      wr(I_PRE, 8'h07);
      pulse(6'b000001);
      gap(8);
      for (int c = 0; c < 4; c++)
      begin
         p = (c == 2);
         x = (c == 0) | ((c == 1) & ~p) | ((c == 3) & p);
         wr(I_OA, {c[1:0], 5'h1E, p});
         wr(I_OB, {4'hF, c[1:0], 1'b0, p});
         pulse(6'b101000);
         check(out_a, x);
         check(out_b, x);
         rdc(I_OA, {c[1:0], 5'h1E, x});
         rdc(I_OB, {4'hF, c[1:0], 1'b0, x});
      end
      wr(I_OA, 8'h48);
      pulse(6'b101000);
      check(out_a, 1'b1);
      wr(I_OA, 8'hFE);
      wr(I_OB, 8'hFE);
      s0 = n_chip;
      pulse(6'b100000);
      check(n_chip - s0, 1);
      pulse(6'b001000);
      check(n_chip - s0, 2);
      wr(I_OA, 8'hFC);
      wr(I_OB, 8'hFC);
      pulse(6'b101000);
      check(n_chip - s0, 2);
      irq_mask <= 6'b011111;
      wr(I_FL, 8'h00);
      pulse(6'b111000);
      check(irq, 4'b0000);
      irq_mask <= '1;
      cyc(3);
      check(irq, 4'b0111);
      rdc(I_FL, 8'h38);
      wr(I_FL, 8'h38);
      rdc(I_FL, 8'h38);
      wr(I_FL, 8'h00);
      rdc(I_FL, 8'h00);
      pulse(6'b000100);
      rdc(I_FL, 8'h80);
      check(irq, 4'b1000);
      wr(I_FL, 8'h01);
      pulse(6'b000100);
      check(irq, 4'b0000);
      pulse(6'b000010);
      check(irq, 4'b1000);
      rdc(I_FL, 8'hC1);
      wr(I_FL, 8'h00);
      s0 = n_sw0;
      s1 = n_sw1;
      bicap <= 1'b1;
      wr(I_FL, 8'hC0);
      cyc(3);
      check(n_sw0 - s0, 1);
      check(n_sw1 - s1, 0);
      bicap <= 1'b0;
      wr(I_FL, 8'h40);
      cyc(3);
      check(n_sw1 - s1, 1);
      results();
   end
endmodule : tiof_timer_io_test
